// >>> design/sensor_ctl_bank.sv
/*
 Control register bank of the barometer: second control register,
 event pin routing, FIFO control and watermark, FIFO data read ports.
 Assumes a serial front end on the same clock delivering byte accesses,
 and a conversion datapath and FIFO that report their state to it.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - Reload bit starts trim copy at once
// - Reload bit self-clears when copy ends
// - Trim copy runs automatically at power-up
// - Polarity bit: 0 active high, 1 low
// - Drive bit: 0 push-pull, 1 open-drain
// - Address auto-steps per byte, resets on
// - Soft clear restores defaults, then self-clears
// - 100/200 Hz forces low current mode
// - Trigger at rate 000 gives one conversion
// - Conversion end clears trigger, latches results
// - Full route: pin shows 128 stored samples
// - Level route: pin shows fill at threshold
// - Overwrite route: pin shows sample overwritten
// - Ready route shows data ready, default off
// - Source select picks data or pressure events
// - Untriggered mode codes: bypass, FIFO, stream
// - Triggered mode codes select triggered modes, except 100: bypass
// - Halt at level: full at watermark count
// - FIFO samples read at 78h to 7Ch
// - Rate 000 is power-down, outputs hold
// - Seven-bit watermark after FIFO control, zero reset
module sensor_ctl_bank
   import sensor_ctl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_acc_start,
   input wire logic [7:0] i_acc_addr,
   input wire logic i_wr_en,
   input wire logic [7:0] i_wr_data,
   input wire logic i_rd_en,
   input wire logic [2:0] i_sample_rate,
   input wire logic i_conv_done,
   input wire logic i_sample_ready,
   input wire logic [7:0] i_fifo_count,
   input wire logic i_fifo_overwrite,
   input wire logic i_press_high,
   input wire logic i_press_low,
   input wire logic [FDATA_W-1:0] i_fifo_sample,
   input wire logic [TRIM_DW-1:0] i_nvm_data,
   output logic [7:0] o_rd_data,
   output logic o_rd_valid,
   output logic o_fifo_pop,
   output logic o_conv_start,
   output logic o_result_latch,
   output logic o_power_down,
   output logic o_low_noise,
   output logic [2:0] o_fifo_mode,
   output logic o_fifo_full,
   output logic o_event_out,
   output logic o_event_oe,
   output logic o_boot_busy,
   output logic [TRIM_AW-1:0] o_nvm_addr,
   output logic o_trim_we,
   output logic [TRIM_AW-1:0] o_trim_addr,
   output logic [TRIM_DW-1:0] o_trim_data
);

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] c2;
      logic [7:0] ev;
      logic [7:0] fc;
      logic [7:0] thr;
      logic [7:0] rd_data;
      logic rd_valid;
      logic pop;
      logic conv_start;
      logic result_latch;
      logic reload_go;
      logic power_down;
      logic low_noise;
      fifo_mode_e fmode;
      logic full;
      logic ev_out;
      logic ev_oe;
   } bank_s;

   bank_s st_r;
   bank_s st_nxt;
   trim_load_if tl ();

   logic full_hit;
   logic level_hit;
   logic data_sig;
   logic ev_active;

   function automatic fifo_mode_e decode_mode(logic trig, logic [1:0] sel);
      fifo_mode_e m;
      m = FM_BYPASS;
      if (sel == FSEL_BYPASS)
         m = FM_BYPASS;
      else if (!trig)
         m = (sel == FSEL_ONE) ? FM_FIFO : FM_STREAM;
      else if (sel == FSEL_ONE)
         m = FM_BYP_TO_FIFO;
      else if (sel == FSEL_TWO)
         m = FM_BYP_TO_STREAM;
      else
         m = FM_STREAM_TO_FIFO;
      return m;
   endfunction

   function automatic logic [7:0] read_byte(bank_s s,
                                            logic [FDATA_W-1:0] smp);
      logic [7:0] b;
      logic [7:0] idx;
      b = 8'h00;
      idx = s.addr - ADDR_FDATA_FIRST;
      if (s.addr == ADDR_CTRL2)
         b = s.c2;
      else if (s.addr == ADDR_EVPIN)
         b = s.ev;
      else if (s.addr == ADDR_FIFOCTL)
         b = s.fc;
      else if (s.addr == ADDR_THRESH)
         b = s.thr;
      else if (s.addr >= ADDR_FDATA_FIRST && s.addr <= ADDR_FDATA_LAST)
         b = smp[idx[2:0]*8 +: 8];
      return b;
   endfunction

   assign full_hit = (i_fifo_count == FIFO_CAP);
   assign level_hit = (i_fifo_count >= {1'b0, st_r.thr[6:0]});

   // Data signal in priority order: ready, level, overwrite, full
   always_comb
   begin
      if (st_r.ev[EV_READY] && i_sample_ready)
         data_sig = 1'b1;
      else if (st_r.ev[EV_LEVEL] && level_hit)
         data_sig = 1'b1;
      else if (st_r.ev[EV_OVR] && i_fifo_overwrite)
         data_sig = 1'b1;
      else
         data_sig = st_r.ev[EV_FULL] && full_hit;
      unique case (st_r.ev[EV_SRC_LO +: 2])
         SRC_DATA: ev_active = data_sig;
         SRC_HIGH: ev_active = i_press_high;
         SRC_LOW: ev_active = i_press_low;
         SRC_EITHER: ev_active = i_press_high || i_press_low;
      endcase
   end

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rd_valid = 1'b0;
      st_nxt.pop = 1'b0;
      st_nxt.conv_start = 1'b0;
      st_nxt.result_latch = 1'b0;
      st_nxt.reload_go = 1'b0;
      if (st_r.c2[C2_SOFT])
      begin
         st_nxt.addr = 8'h00;
         st_nxt.c2 = C2_RESET;
         st_nxt.ev = EV_RESET;
         st_nxt.fc = FC_RESET;
         st_nxt.thr = THR_RESET;
      end
      else
      begin
         if (tl.done)
            st_nxt.c2[C2_RELOAD] = 1'b0;
         if (i_conv_done && st_r.c2[C2_SINGLE])
         begin
            st_nxt.c2[C2_SINGLE] = 1'b0;
            st_nxt.result_latch = 1'b1;
         end
         if (i_acc_start)
            st_nxt.addr = i_acc_addr;
         else if ((i_wr_en || i_rd_en) && st_r.c2[C2_STEP])
         begin
            if (st_r.addr == ADDR_FDATA_LAST)
               st_nxt.addr = ADDR_FDATA_FIRST;
            else
               st_nxt.addr = st_r.addr + ADDR_STEP;
         end
         if (i_wr_en && !i_acc_start)
         begin
            if (st_r.addr == ADDR_CTRL2)
            begin
               // Self-clearing bits are only set by a write
               st_nxt.c2 = i_wr_data & C2_WMASK;
               st_nxt.c2[C2_RELOAD] = i_wr_data[C2_RELOAD]
                  || (st_r.c2[C2_RELOAD] && !tl.done);
               st_nxt.c2[C2_SINGLE] = st_nxt.c2[C2_SINGLE]
                  || (st_r.c2[C2_SINGLE] && !i_conv_done);
               if (i_wr_data[C2_RELOAD] && !tl.busy)
                  st_nxt.reload_go = 1'b1;
               if (i_wr_data[C2_SINGLE])
               begin
                  if (i_sample_rate == RATE_POWER_DOWN && !tl.busy
                      && !st_r.c2[C2_SINGLE])
                     st_nxt.conv_start = 1'b1;
                  else if (!st_r.c2[C2_SINGLE])
                     st_nxt.c2[C2_SINGLE] = 1'b0;
               end
            end
            else if (st_r.addr == ADDR_EVPIN)
               st_nxt.ev = i_wr_data & EV_WMASK;
            else if (st_r.addr == ADDR_FIFOCTL)
               st_nxt.fc = i_wr_data & FC_WMASK;
            else if (st_r.addr == ADDR_THRESH)
               st_nxt.thr = i_wr_data & THR_WMASK;
         end
         if (i_rd_en && !i_acc_start)
         begin
            st_nxt.rd_data = read_byte(st_r, i_fifo_sample);
            st_nxt.rd_valid = 1'b1;
            st_nxt.pop = (st_r.addr == ADDR_FDATA_LAST);
         end
      end
      st_nxt.power_down = (i_sample_rate == RATE_POWER_DOWN);
      st_nxt.low_noise = st_r.c2[C2_QUIET]
         && (i_sample_rate < RATE_100HZ);
      st_nxt.fmode = decode_mode(st_r.fc[FC_TRIG],
                                 st_r.fc[FC_MODE_LO +: 2]);
      if (st_r.fc[FC_HALT])
         st_nxt.full = (i_fifo_count == {1'b0, st_r.thr[6:0]});
      else
         st_nxt.full = full_hit;
      if (st_r.c2[C2_DRIVE])
      begin
         st_nxt.ev_oe = ev_active;
         st_nxt.ev_out = !st_r.c2[C2_POL];
      end
      else
      begin
         st_nxt.ev_oe = 1'b1;
         st_nxt.ev_out = ev_active ^ st_r.c2[C2_POL];
      end
   end

   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_r <= '0;
         st_r.c2 <= C2_RESET;
         st_r.power_down <= 1'b1;
         st_r.ev_oe <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign tl.start = st_r.reload_go;

   trim_loader u_loader (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .bus(tl),
      .i_nvm_data(i_nvm_data),
      .o_nvm_addr(o_nvm_addr),
      .o_trim_we(o_trim_we),
      .o_trim_addr(o_trim_addr),
      .o_trim_data(o_trim_data)
   );

   assign o_rd_data = st_r.rd_data;
   assign o_rd_valid = st_r.rd_valid;
   assign o_fifo_pop = st_r.pop;
   assign o_conv_start = st_r.conv_start;
   assign o_result_latch = st_r.result_latch;
   assign o_power_down = st_r.power_down;
   assign o_low_noise = st_r.low_noise;
   assign o_fifo_mode = st_r.fmode;
   assign o_fifo_full = st_r.full;
   assign o_event_out = st_r.ev_out;
   assign o_event_oe = st_r.ev_oe;
   assign o_boot_busy = tl.busy;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   // Accepted write to control_two
   logic ctrl2_wr;
   assign ctrl2_wr = i_wr_en && !i_acc_start && st_r.addr == ADDR_CTRL2
      && !st_r.c2[C2_SOFT];

   sequence reload_runs;
      tl.start ##1 tl.busy;
   endsequence

   a_reload_kick: assert property (
      ctrl2_wr && i_wr_data[C2_RELOAD] && !tl.busy |=> reload_runs)
      else $error("reload did not start after write");

   a_reload_clear: assert property (
      tl.done && !(ctrl2_wr && i_wr_data[C2_RELOAD]) && !st_r.c2[C2_SOFT]
         |=> !st_r.c2[C2_RELOAD])
      else $error("reload bit not cleared at end");

   a_pin_level: assert property (
      !st_r.c2[C2_DRIVE] |=> o_event_oe
         && o_event_out == ($past(ev_active) ^ $past(st_r.c2[C2_POL])))
      else $error("event pin level wrong");

   a_od_release: assert property (
      st_r.c2[C2_DRIVE] && !ev_active |=> !o_event_oe)
      else $error("open-drain pin driven while idle");

   a_addr_step: assert property (
      i_rd_en && !i_acc_start && !st_r.c2[C2_SOFT] && st_r.c2[C2_STEP]
         && st_r.addr < ADDR_FDATA_LAST
         |=> st_r.addr == $past(st_r.addr) + ADDR_STEP)
      else $error("address did not step");

   a_soft_default: assert property (
      st_r.c2[C2_SOFT] |=> st_r.c2 == C2_RESET && st_r.ev == EV_RESET
         && st_r.fc == FC_RESET && st_r.thr == THR_RESET)
      else $error("soft clear left a register changed");

   a_quiet_gate: assert property (
      i_sample_rate >= RATE_100HZ |=> !o_low_noise)
      else $error("low noise active at high rate");

   a_single_start: assert property (
      ctrl2_wr && i_wr_data[C2_SINGLE]
         && i_sample_rate != RATE_POWER_DOWN
         |=> !o_conv_start)
      else $error("conversion started outside power-down");

   a_single_end: assert property (
      i_conv_done && st_r.c2[C2_SINGLE] && !st_r.c2[C2_SOFT]
         && !(ctrl2_wr && i_wr_data[C2_SINGLE])
         |=> o_result_latch && !st_r.c2[C2_SINGLE])
      else $error("conversion end not handled");

   a_full_route: assert property (
      st_r.ev[EV_FULL] && st_r.ev[EV_SRC_LO +: 2] == SRC_DATA
         && !st_r.c2[C2_DRIVE] && !st_r.c2[C2_POL] && full_hit
         |=> o_event_out)
      else $error("full not routed to event pin");

   a_mode_bypass: assert property (
      st_r.fc[FC_MODE_LO +: 2] == FSEL_BYPASS |=> o_fifo_mode == FM_BYPASS)
      else $error("bypass mode not selected");

   a_halt_full: assert property (
      st_r.fc[FC_HALT] && i_fifo_count == {1'b0, st_r.thr[6:0]}
         |=> o_fifo_full)
      else $error("watermark halt not flagged full");

   a_fifo_pop: assert property (
      i_rd_en && !i_acc_start && !st_r.c2[C2_SOFT]
         && st_r.addr == ADDR_FDATA_LAST |=> o_fifo_pop && o_rd_valid)
      else $error("last FIFO byte read did not pop");

endmodule

// >>> design/sensor_ctl_pkg.sv
/*
 Constants, field layouts and state types shared by the barometer
 control register bank and its trim loader.
 Assumes a single 250 MHz clock domain for every user of this package.
*/
package sensor_ctl_pkg;

   // Register addresses on the serial register port
   localparam logic [7:0] ADDR_CTRL2 = 8'h11;
   localparam logic [7:0] ADDR_EVPIN = 8'h12;
   localparam logic [7:0] ADDR_FIFOCTL = 8'h13;
   localparam logic [7:0] ADDR_THRESH = 8'h14;
   localparam logic [7:0] ADDR_FDATA_FIRST = 8'h78;
   localparam logic [7:0] ADDR_FDATA_LAST = 8'h7c;
   localparam logic [7:0] ADDR_STEP = 8'h01;

   // control_two fields
   localparam int C2_RELOAD = 7;
   localparam int C2_POL = 6;
   localparam int C2_DRIVE = 5;
   localparam int C2_STEP = 4;
   localparam int C2_SOFT = 2;
   localparam int C2_QUIET = 1;
   localparam int C2_SINGLE = 0;

   // event_pin_control fields
   localparam int EV_FULL = 5;
   localparam int EV_LEVEL = 4;
   localparam int EV_OVR = 3;
   localparam int EV_READY = 2;
   localparam int EV_SRC_LO = 0;

   // fifo_control fields
   localparam int FC_HALT = 3;
   localparam int FC_TRIG = 2;
   localparam int FC_MODE_LO = 0;

   // Reset values and writable-bit masks
   localparam logic [7:0] C2_RESET = 8'h10;
   localparam logic [7:0] EV_RESET = 8'h00;
   localparam logic [7:0] FC_RESET = 8'h00;
   localparam logic [7:0] THR_RESET = 8'h00;
   localparam logic [7:0] C2_WMASK = 8'hf7;
   localparam logic [7:0] EV_WMASK = 8'h3f;
   localparam logic [7:0] FC_WMASK = 8'h0f;
   localparam logic [7:0] THR_WMASK = 8'h7f;

   localparam logic [2:0] RATE_POWER_DOWN = 3'h0;
   localparam logic [2:0] RATE_100HZ = 3'h6;
   localparam logic [7:0] FIFO_CAP = 8'h80;

   localparam logic [1:0] SRC_DATA = 2'h0;
   localparam logic [1:0] SRC_HIGH = 2'h1;
   localparam logic [1:0] SRC_LOW = 2'h2;
   localparam logic [1:0] SRC_EITHER = 2'h3;

   localparam logic [1:0] FSEL_BYPASS = 2'h0;
   localparam logic [1:0] FSEL_ONE = 2'h1;
   localparam logic [1:0] FSEL_TWO = 2'h2;

   localparam int FDATA_W = 40;
   localparam int TRIM_AW = 4;
   localparam int TRIM_DW = 8;
   localparam logic [TRIM_AW-1:0] TRIM_LAST = 4'hf;
   localparam logic [TRIM_AW-1:0] TRIM_STEP = 4'h1;

   typedef enum logic [2:0] {
      FM_BYPASS = 3'h0,
      FM_FIFO = 3'h1,
      FM_STREAM = 3'h2,
      FM_BYP_TO_FIFO = 3'h3,
      FM_BYP_TO_STREAM = 3'h4,
      FM_STREAM_TO_FIFO = 3'h5
   } fifo_mode_e;

   typedef enum logic [1:0] {
      LD_IDLE = 2'h0,
      LD_ADDR = 2'h1,
      LD_COPY = 2'h2
   } load_state_e;

endpackage

// >>> design/trim_load_if.sv
/*
 Handshake between the register bank and the trim loader.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface trim_load_if;
   logic start;
   logic busy;
   logic done;
   modport ctrl (output start, input busy, input done);
   modport ldr (input start, output busy, output done);
endinterface

// >>> design/trim_loader.sv
/*
 Copies factory calibration words from nonvolatile storage into the
 trimming registers, at power-up and on request.
 Assumes nonvolatile data is valid one cycle after its address.
*/
`timescale 1ns/10ps
module trim_loader
   import sensor_ctl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_reset,
   trim_load_if.ldr bus,
   input wire logic [TRIM_DW-1:0] i_nvm_data,
   output logic [TRIM_AW-1:0] o_nvm_addr,
   output logic o_trim_we,
   output logic [TRIM_AW-1:0] o_trim_addr,
   output logic [TRIM_DW-1:0] o_trim_data
);

   typedef struct packed {
      load_state_e state;
      logic [TRIM_AW-1:0] nvm_addr;
      logic we;
      logic [TRIM_AW-1:0] trim_addr;
      logic [TRIM_DW-1:0] trim_data;
      logic busy;
      logic done;
   } load_s;

   load_s st_r;
   load_s st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.we = 1'b0;
      st_nxt.done = 1'b0;
      unique case (st_r.state)
         LD_IDLE:
         begin
            if (bus.start)
            begin
               st_nxt.state = LD_ADDR;
               st_nxt.nvm_addr = '0;
               st_nxt.busy = 1'b1;
            end
         end
         LD_ADDR:
            st_nxt.state = LD_COPY;
         LD_COPY:
         begin
            st_nxt.we = 1'b1;
            st_nxt.trim_addr = st_r.nvm_addr;
            st_nxt.trim_data = i_nvm_data;
            if (st_r.nvm_addr == TRIM_LAST)
            begin
               st_nxt.state = LD_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end
            else
            begin
               st_nxt.state = LD_ADDR;
               st_nxt.nvm_addr = st_r.nvm_addr + TRIM_STEP;
            end
         end
         default:
            st_nxt.state = LD_IDLE;
      endcase
   end

   // Power-up boot starts straight out of reset
   always_ff @(posedge i_mclk or posedge i_reset)
   begin
      if (i_reset)
      begin
         st_r <= '0;
         st_r.state <= LD_ADDR;
         st_r.busy <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign bus.busy = st_r.busy;
   assign bus.done = st_r.done;
   assign o_nvm_addr = st_r.nvm_addr;
   assign o_trim_we = st_r.we;
   assign o_trim_addr = st_r.trim_addr;
   assign o_trim_data = st_r.trim_data;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   a_boot_at_release: assert property (
      $fell(i_reset) |-> bus.busy && st_r.nvm_addr == '0)
      else $error("power-up trim copy not running");

   a_copy_word: assert property (
      st_r.state == LD_COPY |=> o_trim_we
         && o_trim_data == $past(i_nvm_data))
      else $error("trim word not copied");

endmodule

// >>> sim/sensor_far_model.sv
/*
 Far side of the bank: calibration storage and conversion datapath.
 Assumes the bank's clock; the bench sets the conversion delay.
*/
`timescale 1ns/10ps
module sensor_far_model
   import sensor_ctl_pkg::*;
(
   input wire logic i_mclk,
   input wire logic [TRIM_AW-1:0] i_nvm_addr,
   input wire logic i_conv_start,
   input wire logic [7:0] i_conv_wait,
   output logic [TRIM_DW-1:0] o_nvm_data,
   output logic o_conv_done
);
   int left = 0;
   initial o_conv_done = 1'b0;
   // Word is a fixed scramble of its address
   always @(posedge i_mclk)
      o_nvm_data <= {i_nvm_addr, ~i_nvm_addr} ^ 8'h5a;
   // One measurement per start, after a set delay
   always @(posedge i_mclk)
   begin
      o_conv_done <= (left == 1);
      if (i_conv_start)
         left <= i_conv_wait;
      else if (left > 0)
         left <= left - 1;
   end
endmodule

// >>> sim/tb.sv
/*
 Self-checking bench for the control register bank.
 Assumes the far side model; a register model is kept here.
*/
`timescale 1ns/10ps
module tb
   import sensor_ctl_pkg::*;
;
   logic i_mclk, i_reset, i_acc_start, i_wr_en, i_rd_en, i_conv_done;
   logic [7:0] i_acc_addr, i_wr_data, i_fifo_count, conv_wait, o_rd_data;
   logic [2:0] i_sample_rate, o_fifo_mode;
   logic i_sample_ready, i_fifo_overwrite, i_press_high, i_press_low;
   logic [FDATA_W-1:0] i_fifo_sample;
   logic [TRIM_DW-1:0] i_nvm_data, o_trim_data;
   logic o_rd_valid, o_fifo_pop, o_conv_start, o_result_latch;
   logic o_power_down, o_low_noise, o_fifo_full, o_event_out;
   logic o_event_oe, o_boot_busy, o_trim_we;
   logic [TRIM_AW-1:0] o_nvm_addr, o_trim_addr;
   int fail_count = 0;
   int n_tests = 0;
   int n_trim = 0;
   int mdl[int];
   logic [7:0] ra [5] = '{ADDR_CTRL2, ADDR_EVPIN, ADDR_FIFOCTL,
      ADDR_THRESH, 8'h20};

   sensor_ctl_bank sensor_ctl_bank_i (.*);
   sensor_far_model sensor_far_model_i (.i_mclk(i_mclk),
      .i_nvm_addr(o_nvm_addr), .i_conv_start(o_conv_start),
      .i_conv_wait(conv_wait), .o_nvm_data(i_nvm_data),
      .o_conv_done(i_conv_done));

   initial
   begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end

   task automatic cyc(int n = 1);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   function automatic logic [7:0] wmask(logic [7:0] a);
      case (a)
         ADDR_CTRL2: return C2_WMASK;
         ADDR_EVPIN: return EV_WMASK;
         ADDR_FIFOCTL: return FC_WMASK;
         default: return THR_WMASK;
      endcase
   endfunction
   function automatic logic [7:0] xp(logic [7:0] a);
      return mdl.exists(a) ? 8'(mdl[a]) : 8'h00;
   endfunction
   task automatic mreset;
      mdl[8'h11] = C2_RESET;
      mdl[8'h12] = EV_RESET;
      mdl[8'h13] = FC_RESET;
      mdl[8'h14] = THR_RESET;
   endtask
   task automatic acc(logic [7:0] a);
      i_acc_start = 1'b1;
      i_acc_addr = a;
      cyc();
      i_acc_start = 1'b0;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      acc(a);
      i_wr_en = 1'b1;
      i_wr_data = d;
      cyc();
      i_wr_en = 1'b0;
      if (mdl.exists(a))
         mdl[a] = d & wmask(a);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e, string m);
      acc(a);
      i_rd_en = 1'b1;
      cyc();
      i_rd_en = 1'b0;
      chk(o_rd_valid, 1'b1, m);
      chk(o_rd_data, e, m);
   endtask
   task automatic rdall(string m);
      foreach (ra[i]) rd(ra[i], xp(ra[i]), m);
      $display("test %s done", m);
   endtask
   task automatic wait_busy;
      for (int k = 0; k < 100 && o_boot_busy !== 1'b0; k++) cyc();
      chk(o_boot_busy, 1'b0, "boot end");
      cyc();
   endtask
   task automatic ev_case(logic [7:0] ev, logic pol, logic drv);
      logic act, dat;
      int wm;
      wm = $urandom % 128;
      i_fifo_count = 8'($urandom % 129);
      {i_sample_ready, i_fifo_overwrite, i_press_high, i_press_low} =
         4'($urandom);
      wr(ADDR_EVPIN, ev);
      wr(ADDR_THRESH, 8'(wm));
      wr(ADDR_CTRL2, {1'b0, pol, drv, 5'h10});
      cyc(2);
      dat = (ev[2] & i_sample_ready) | (ev[4] & (i_fifo_count >= wm))
         | (ev[3] & i_fifo_overwrite) | (ev[5] & (i_fifo_count == 128));
      case (ev[1:0])
         2'h0: act = dat;
         2'h1: act = i_press_high;
         2'h2: act = i_press_low;
         default: act = i_press_high | i_press_low;
      endcase
      chk(o_fifo_full, i_fifo_count == 128, "full");
      chk(o_event_oe, drv ? act : 1'b1, "oe");
      chk(o_event_out, drv ? !pol : act ^ pol, "pin");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Every copied word must match the stored one
   always @(negedge i_mclk)
      if (o_trim_we === 1'b1)
      begin
         n_trim++;
         chk(o_trim_data, {o_trim_addr, ~o_trim_addr} ^ 8'h5a, "word");
      end

   initial
   begin
      repeat (20000) @(posedge i_mclk);
      fail_count++;
      $display("[FAIL] %0t watchdog", $time);
      final_report();
   end

   initial
   begin
      {i_acc_start, i_wr_en, i_rd_en, i_acc_addr, i_wr_data} = '0;
      {i_sample_ready, i_fifo_overwrite, i_press_high, i_press_low} = '0;
      i_sample_rate = 3'h0;
      i_fifo_count = 8'h00;
      i_fifo_sample = '0;
      conv_wait = 8'h06;
      i_reset = 1'b1;
      void'($urandom(32'hc5e3));
      mreset();
      cyc(12);
      i_reset = 1'b0;
      chk(o_boot_busy, 1'b1, "boot");
      wait_busy();
      chk(8'(n_trim), 8'd16, "boot words");
      rdall("defaults");
      repeat (4)
      begin
         for (int i = 1; i < 5; i++) wr(ra[i], 8'($urandom));
         rdall("rw");
      end
      for (int k = 0; k < 8; k++)
      begin
         wr(ADDR_FIFOCTL, 8'(k));
         cyc(2);
         chk(o_fifo_mode, k[1:0] == 0 ? 0 : !k[2] ? (k[1] ? 2 : 1)
            : k[1:0] + 2, "mode");
      end
      $display("test mode done");
      wr(ADDR_FIFOCTL, 8'h00);
      repeat (32) ev_case(8'($urandom) & 8'h3f, 1'($urandom),
         1'($urandom));
      wr(ADDR_CTRL2, 8'h10);
      wr(ADDR_EVPIN, 8'h20);
      i_fifo_count = FIFO_CAP;
      cyc(2);
      chk(o_event_out, 1'b1, "full pin");
      $display("test event done");
      wr(ADDR_FIFOCTL, 8'h08);
      wr(ADDR_THRESH, 8'h21);
      i_fifo_count = 8'h21;
      cyc(2);
      chk(o_fifo_full, 1'b1, "halt");
      i_fifo_count = 8'h20;
      cyc(2);
      chk(o_fifo_full, 1'b0, "halt below");
      wr(ADDR_FIFOCTL, 8'h00);
      // Quiet bit changed only while powered down
      wr(ADDR_CTRL2, 8'h12);
      for (int r = 0; r < 8; r++)
      begin
         i_sample_rate = 3'(r);
         cyc(2);
         chk(o_low_noise, r < 6, "quiet");
         chk(o_power_down, r == 0, "power down");
      end
      $display("test rate done");
      i_sample_rate = 3'h0;
      wr(ADDR_CTRL2, 8'h10);
      conv_wait = 8'(6 + $urandom % 20);
      wr(ADDR_CTRL2, 8'h11);
      chk(o_conv_start, 1'b1, "one shot");
      mdl[8'h11] = 8'h11;
      rd(ADDR_CTRL2, xp(ADDR_CTRL2), "shot busy");
      for (int k = 0; k < 40 && o_result_latch !== 1'b1; k++) cyc();
      chk(o_result_latch, 1'b1, "latch");
      mdl[8'h11] = 8'h10;
      rd(ADDR_CTRL2, xp(ADDR_CTRL2), "shot clear");
      i_sample_rate = 3'h1;
      wr(ADDR_CTRL2, 8'h11);
      chk(o_conv_start, 1'b0, "no shot");
      mdl[8'h11] = 8'h10;
      rd(ADDR_CTRL2, xp(ADDR_CTRL2), "no shot");
      i_sample_rate = 3'h0;
      $display("test one shot done");
      wr(ADDR_CTRL2, 8'h90);
      cyc();
      chk(o_boot_busy, 1'b1, "reload");
      wait_busy();
      cyc(2);
      mdl[8'h11] = 8'h10;
      rd(ADDR_CTRL2, xp(ADDR_CTRL2), "reload clear");
      chk(8'(n_trim), 8'd32, "reload words");
      i_fifo_sample = {8'($urandom), $urandom};
      acc(ADDR_FDATA_FIRST);
      i_rd_en = 1'b1;
      for (int i = 0; i < 5; i++)
      begin
         cyc();
         if (i == 4)
            i_rd_en = 1'b0;
         chk(o_rd_data, i_fifo_sample[8*i+:8], "burst");
         chk(o_fifo_pop, i == 4, "pop");
      end
      rd(8'h7a, i_fifo_sample[23:16], "single");
      wr(ADDR_CTRL2, 8'h00);
      acc(ADDR_FDATA_FIRST);
      i_rd_en = 1'b1;
      cyc(2);
      i_rd_en = 1'b0;
      chk(o_rd_data, i_fifo_sample[7:0], "no step");
      $display("test fifo data done");
      wr(ADDR_EVPIN, 8'h3f);
      wr(ADDR_THRESH, 8'h7f);
      wr(ADDR_CTRL2, 8'h74);
      cyc(2);
      mreset();
      rdall("soft clear");
      final_report();
   end
endmodule
